//--- rtl/keypad_pkg.sv
// package: constants and types for the keypad encoder with interrupt
package keypad_pkg;

  // key codes for the numeric group
  localparam logic [3:0] KEY_POINT_CODE = 4'ha;  // decimal point
  localparam logic [3:0] KEY_ENTER_CODE = 4'hb;  // enter key
  localparam int         NUM_DIGIT_KEYS = 10;    // digits 0..9

  // key matrix sizes: 12 numeric keys, 16 function keys
  localparam int         NUM_KEYS       = 12;
  localparam int         FUNC_KEYS      = 16;
  localparam int         FUNC_IDX_W     = 4;

  // display write strobe timing
  localparam int         DISP_PERIOD_NS = 1000;  // strobe repeat period
  localparam int         CLK_PERIOD_NS  = 5;     // ref_clk period
  localparam int         DISP_PERIOD_CYC = DISP_PERIOD_NS / CLK_PERIOD_NS;
  localparam int         DISP_CNT_W     = 8;
  localparam logic [DISP_CNT_W-1:0] DISP_LAST =
    DISP_CNT_W'(DISP_PERIOD_CYC - 1);

  // latched key report travelling to the processor side
  typedef struct packed {
    logic       group_left;  // high for function group
    logic [3:0] code;        // key code, bit 0 is lsb
  } key_report_type;

  localparam key_report_type REPORT_RESET = '{group_left: 1'b0, code: 4'h0};

  // interrupt state machine
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,  // waiting for a press
    ST_PENDING = 2'b01,  // request asserted
    ST_RELEASE = 2'b11   // waiting for all keys released
  } irq_state_type;

endpackage : keypad_pkg

//--- rtl/keypad_encoder_irq.sv
// module: keypad encoder with active-low interrupt request
`timescale 1ns/1ps
`default_nettype none
module keypad_encoder_irq (
  input  wire logic                            ref_clk,
  input  wire logic                            sys_rst,
  input  wire logic [keypad_pkg::NUM_KEYS-1:0]  numeric_keys,
  input  wire logic [keypad_pkg::FUNC_KEYS-1:0] function_keys,
  input  wire logic                            keyboard_read_strobe_n,
  output var  logic                            key_interrupt_request_n,
  output var  keypad_pkg::key_report_type      key_report,
  output var  logic                            display_write_strobe
);
  import keypad_pkg::*;

  // encode a numeric key index into its code (index 10 point, 11 enter)
  function automatic logic [3:0] numeric_code(
    input logic [NUM_KEYS-1:0] keys
  );
    logic [3:0] c;
    c = 4'h0;
    for (int i = NUM_KEYS - 1; i >= 0; i--) begin
      if (keys[i]) begin
        c = 4'(i);
      end
    end
    return c;
  endfunction : numeric_code

  // encode the lowest pressed function key index
  function automatic logic [3:0] function_code(
    input logic [FUNC_KEYS-1:0] keys
  );
    logic [3:0] c;
    c = 4'h0;
    for (int i = FUNC_KEYS - 1; i >= 0; i--) begin
      if (keys[i]) begin
        c = FUNC_IDX_W'(i);
      end
    end
    return c;
  endfunction : function_code

  // three-stage synchronisers for pins
  logic [NUM_KEYS-1:0]  num_s1_q, num_s2_q, num_s3_q;
  logic [FUNC_KEYS-1:0] fn_s1_q,  fn_s2_q,  fn_s3_q;
  logic [2:0]           rd_sync_q;  // read strobe, active low
  logic [NUM_KEYS-1:0]  num_stable_q;  // accepted numeric key levels
  logic [FUNC_KEYS-1:0] fn_stable_q;   // accepted function key levels
  logic                 rd_low_q;      // accepted read strobe level

  // synchronise and accept a change once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      num_s1_q     <= '0;
      num_s2_q     <= '0;
      num_s3_q     <= '0;
      fn_s1_q      <= '0;
      fn_s2_q      <= '0;
      fn_s3_q      <= '0;
      rd_sync_q    <= 3'h7;
      num_stable_q <= '0;
      fn_stable_q  <= '0;
      rd_low_q     <= 1'b0;
    end else begin
      num_s1_q  <= numeric_keys;
      num_s2_q  <= num_s1_q;
      num_s3_q  <= num_s2_q;
      fn_s1_q   <= function_keys;
      fn_s2_q   <= fn_s1_q;
      fn_s3_q   <= fn_s2_q;
      rd_sync_q <= {rd_sync_q[1:0], keyboard_read_strobe_n};
      for (int i = 0; i < NUM_KEYS; i++) begin
        if (num_s2_q[i] == num_s3_q[i]) begin
          num_stable_q[i] <= num_s3_q[i];
        end
      end
      for (int i = 0; i < FUNC_KEYS; i++) begin
        if (fn_s2_q[i] == fn_s3_q[i]) begin
          fn_stable_q[i] <= fn_s3_q[i];
        end
      end
      if (rd_sync_q[1] == rd_sync_q[2]) begin
        rd_low_q <= ~rd_sync_q[2];
      end
    end
  end

  // interrupt and latch state
  irq_state_type  state_q, state_d;
  key_report_type report_q, report_d;
  logic           irq_n_q, irq_n_d;
  logic           any_key;     // some key currently held
  logic           rd_low_d1_q; // previous read level for edge detect
  logic           rd_fall;     // start of a keyboard read

  assign any_key = (|num_stable_q) | (|fn_stable_q);
  assign rd_fall = rd_low_q & ~rd_low_d1_q;

  // next-state logic for request, latch and press tracking
  always_comb begin
    state_d  = state_q;
    report_d = report_q;
    irq_n_d  = irq_n_q;
    unique case (state_q)
      // new press: latch report and raise request
      ST_IDLE: begin
        if (any_key) begin
          state_d = ST_PENDING;
          irq_n_d = 1'b0;
          if (|fn_stable_q) begin
            report_d.group_left = 1'b1;
            report_d.code       = function_code(fn_stable_q);
          end else begin
            report_d.group_left = 1'b0;
            report_d.code       = numeric_code(num_stable_q);
          end
        end
      end
      // request held, report frozen until the read
      ST_PENDING: begin
        if (rd_fall) begin
          irq_n_d = 1'b1;
          state_d = ST_RELEASE;
        end
      end
      // one request per press: wait for release
      ST_RELEASE: begin
        if (!any_key) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // register request state; report changes only in idle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q     <= ST_IDLE;
      report_q    <= REPORT_RESET;
      irq_n_q     <= 1'b1;
      rd_low_d1_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      report_q    <= report_d;
      irq_n_q     <= irq_n_d;
      rd_low_d1_q <= rd_low_q;
    end
  end

  assign key_interrupt_request_n = irq_n_q;
  assign key_report              = report_q;

  // display write strobe: first pulse right after reset, then periodic
  logic [DISP_CNT_W-1:0] disp_cnt_q, disp_cnt_d;
  logic                  disp_q, disp_d;

  // period counter wraps at the last count; pulse when it sits at zero
  always_comb begin
    disp_cnt_d = (disp_cnt_q == DISP_LAST) ? '0
                 : DISP_CNT_W'(disp_cnt_q + 1'b1);
    disp_d     = (disp_cnt_q == '0);
  end

  // register counter and strobe; counter at zero gives the power-up pulse
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      disp_cnt_q <= '0;
      disp_q     <= 1'b0;
    end else begin
      disp_cnt_q <= disp_cnt_d;
      disp_q     <= disp_d;
    end
  end

  assign display_write_strobe = disp_q;

  // checks: request, clear, report hold, codes and strobe period
  a_press_raises_irq: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    state_q == ST_IDLE && any_key |=> !key_interrupt_request_n)
    else $error("press did not raise request");
  a_irq_held_low: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    !key_interrupt_request_n && !rd_fall |=> !key_interrupt_request_n)
    else $error("request dropped without read");
  a_read_clears_irq: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    state_q == ST_PENDING && rd_fall |=> key_interrupt_request_n)
    else $error("read did not clear request");
  a_report_stable: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    !key_interrupt_request_n && $past(!key_interrupt_request_n)
      |-> $stable(key_report))
    else $error("report changed while pending");
  a_numeric_code: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    state_q == ST_IDLE && num_stable_q == 12'h800 && fn_stable_q == '0
      |=> key_report.code == KEY_ENTER_CODE && !key_report.group_left)
    else $error("enter code wrong");
  a_group_flag: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    state_q == ST_IDLE && (|fn_stable_q) |=> key_report.group_left)
    else $error("group flag not set");
  a_disp_first: assert property (
    @(posedge ref_clk)
    $fell(sys_rst) |-> ##1 display_write_strobe)
    else $error("no strobe after power-up");
  a_disp_repeat: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    $rose(display_write_strobe) |=> !display_write_strobe ##199
      display_write_strobe)
    else $error("strobe period wrong");

  c_press: cover property (@(posedge ref_clk) $fell(key_interrupt_request_n));
  c_clear: cover property (@(posedge ref_clk) $rose(key_interrupt_request_n));
  c_func: cover property (@(posedge ref_clk)
    $fell(key_interrupt_request_n) && key_report.group_left);
  c_disp: cover property (@(posedge ref_clk) $rose(display_write_strobe));

endmodule : keypad_encoder_irq
`default_nettype wire

//--- dv/cpu_reader_model.sv
// processor model that answers a key interrupt with a keyboard read
`timescale 1ns/1ps
`default_nettype none
module cpu_reader_model (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       read_enable,
  input  wire logic [7:0] read_delay,
  input  wire logic       key_interrupt_request_n,
  output var  logic       keyboard_read_strobe_n
);
  logic [7:0] wait_q;  // cycles the request has waited
  // wait read_delay cycles, then hold the read low until the request clears
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !read_enable || key_interrupt_request_n) begin
      wait_q                 <= 8'h00;
      keyboard_read_strobe_n <= 1'b1;
    end else begin
      wait_q                 <= wait_q + 8'h01;
      keyboard_read_strobe_n <= (wait_q < read_delay);
    end
  end
endmodule : cpu_reader_model
`default_nettype wire

//--- dv/tb_top.sv
// self-checking bench for the keypad encoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import keypad_pkg::*;
  logic           ref_clk = 1'b0;   // 200 MHz clock
  logic           sys_rst = 1'b1;   // synchronous reset
  logic [11:0]    numeric_keys = 12'h000;
  logic [15:0]    function_keys = 16'h0000;
  logic           read_enable = 1'b0;  // lets the processor model read
  logic [7:0]     read_delay = 8'h02;  // processor answer delay
  logic           read_n;           // keyboard read strobe
  logic           irq_n;            // interrupt request
  key_report_type key_report;       // latched code and group
  logic           strobe;           // display write strobe
  int             bad_count = 0;
  int             n_compared = 0;
  int             k;
  always #2.5 ref_clk = ~ref_clk;
  keypad_encoder_irq u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .numeric_keys(numeric_keys), .function_keys(function_keys),
    .keyboard_read_strobe_n(read_n), .key_interrupt_request_n(irq_n),
    .key_report(key_report), .display_write_strobe(strobe));
  cpu_reader_model u_cpu (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .read_enable(read_enable), .read_delay(read_delay),
    .key_interrupt_request_n(irq_n), .keyboard_read_strobe_n(read_n));
  // compare one value and count it
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // print counts and verdict, then stop
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  // wait up to 60 cycles for the request line to reach a level
  task automatic wait_irq(input logic lvl);
    for (k = 0; k < 60 && irq_n !== lvl; k++) @(negedge ref_clk);
    if (irq_n !== lvl) begin
      check("irq_wait", 8'(irq_n), 8'(lvl));
      print_verdict();
    end
  endtask : wait_irq
  // strobe pulses after reset, then once every 200 cycles
  task automatic test_strobe();
    check("irq_reset", 8'(irq_n), 8'h01);
    check("report_reset", 8'(key_report), 8'h00);
    for (k = 0; k < 300 && strobe !== 1'b1; k++) @(negedge ref_clk);
    check("strobe_first", 8'(strobe), 8'h01);
    if (strobe !== 1'b1) print_verdict();
    @(negedge ref_clk);
    for (k = 1; k < 300 && strobe !== 1'b1; k++) @(negedge ref_clk);
    check("strobe_period", 8'(k), 8'(DISP_PERIOD_CYC));
    if (strobe !== 1'b1) print_verdict();
    $display("test strobe done");
  endtask : test_strobe
  // press, hold, add key 0 while pending, read, release, recheck report
  task automatic do_key(input logic [15:0] f, input logic [11:0] n,
                        input logic [4:0] exp);
    @(posedge ref_clk);
    function_keys <= f;
    numeric_keys  <= n;
    wait_irq(1'b0);
    repeat (20) @(negedge ref_clk);
    check("irq_held", 8'(irq_n), 8'h00);
    check("report", 8'(key_report), 8'(exp));
    @(posedge ref_clk);
    numeric_keys <= n | 12'h001;
    read_enable  <= 1'b1;
    wait_irq(1'b1);
    check("report_read", 8'(key_report), 8'(exp));
    @(posedge ref_clk);
    read_enable   <= 1'b0;
    function_keys <= 16'h0000;
    numeric_keys  <= 12'h000;
    repeat (12) @(negedge ref_clk);
    check("irq_idle", 8'(irq_n), 8'h01);
    check("report_kept", 8'(key_report), 8'(exp));
  endtask : do_key
  // every numeric key, point and enter included, group flag low
  task automatic test_numeric();
    read_delay <= 8'h02;
    for (int i = 11; i >= 0; i--) do_key(16'h0, 12'(1 << i), 5'(i));
    $display("test numeric done");
  endtask : test_numeric
  // every function key with a slow read, group flag high
  task automatic test_function();
    read_delay <= 8'h28;
    for (int i = 0; i < FUNC_KEYS; i++)
      do_key(16'(1 << i), 12'h000, {1'b1, 4'(i)});
    do_key(16'h0020, 12'h008, 5'h15);  // function group wins
    $display("test function done");
  endtask : test_function
  initial begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(negedge ref_clk);
    test_strobe();
    test_numeric();
    test_function();
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
